// >>> logic/dsph_pkg.sv
// package: constants, states and rule summary for the deep-sleep power handshake
// How it works
// - soft-off sleep output asserted low while the system sits in S5.
// - deep-sleep indication driven low on entering deep sleep.
// - deep-sleep indication driven high on leaving deep sleep.
// - suspend-warning driven low before deep sleep entry removes primary power.
// - no wake accepted while warning asserted and acknowledge not.
// - power-down-acknowledge high when engine no longer needs primary power and the system is out of S0.
// - warning and power-down-acknowledge share one pin, chosen by deep-sleep support.
// - holdoff input delays sleep exit after active-well control deasserts.
// - reset exit begins only once system power good is seen.
// - suspend clock output is a buffered copy of the real-time clock.
// - active-well control output drives an internal power good timed from it.
package dsph_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned ACTIVE_PG_DELAY_NS = 1000;
  localparam int unsigned ACTIVE_PG_CYCLES  =
    (ACTIVE_PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PG_CNT_W          = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_SOFT_OFF_N  = 1'b0;
  localparam logic RST_DEEP_N      = 1'b1;
  localparam logic RST_WARN_N      = 1'b1;
  localparam logic RST_ACTIVE_N    = 1'b0;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    ST_S0,
    ST_SX,
    ST_WARN,
    ST_DEEP,
    ST_UNWARN,
    ST_EXIT
  } dsph_state_e;
endpackage

// >>> logic/dsph_sync.sv
// two-flop synchroniser for one asynchronous level
module dsph_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic rstVal,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  // reset value is always zero; rstVal is tied at the instance but not used
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// >>> logic/dsph_top.sv
// deep-sleep power handshake sequencer
module dsph_top
  import dsph_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic rtcClk,
  input  wire logic system_power_good,
  input  wire logic suspend_ack_n,
  input  wire logic sleep_exit_holdoff_n,
  input  wire logic deepSleepSupported,
  input  wire logic sleepReq,
  input  wire logic s5Req,
  input  wire logic deepReq,
  input  wire logic wakeReq,
  input  wire logic engineIdle,
  output logic      soft_off_sleep_n,
  output logic      deep_sleep_state_n,
  output logic      suspend_warn_n,
  output logic      suspend_clock_out,
  output logic      activeSleepCtl_n,
  output logic      active_well_power_good,
  output logic      resetExit,
  output logic      wakeTaken
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic pgS, ackS, holdS, rtcS;
  logic ackN;
  logic holdN;
  // inverted at the boundary so both active-low pins idle deasserted after reset
  logic ackRaw, holdRaw;
  assign ackRaw  = ~suspend_ack_n;
  assign holdRaw = ~sleep_exit_holdoff_n;
  dsph_sync uPg   (.mclk(mclk), .rst(rst), .rstVal(1'b0), .din(system_power_good), .dout(pgS));
  dsph_sync uAck  (.mclk(mclk), .rst(rst), .rstVal(1'b0), .din(ackRaw), .dout(ackS));
  dsph_sync uHold (.mclk(mclk), .rst(rst), .rstVal(1'b0), .din(holdRaw), .dout(holdS));
  dsph_sync uRtc  (.mclk(mclk), .rst(rst), .rstVal(1'b0), .din(rtcClk), .dout(rtcS));
  assign ackN  = ~ackS;
  assign holdN = ~holdS;

  // ****************************************
  // sequencer
  // ****************************************
  dsph_state_e state_q;
  logic warnLevel;
  assign warnLevel = (state_q == ST_WARN) || (state_q == ST_DEEP);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_S0;
    end else begin
      case (state_q)
        ST_S0: begin
          if (sleepReq) begin
            state_q <= ST_SX;
          end
        end
        ST_SX: begin
          if (wakeReq) begin
            state_q <= ST_EXIT;
          end else if (deepReq && deepSleepSupported) begin
            state_q <= ST_WARN;
          end
        end
        ST_WARN: begin
          // no wake is honoured until the controller acknowledges
          if (!ackN) begin
            state_q <= ST_DEEP;
          end
        end
        ST_DEEP: begin
          if (wakeReq) begin
            state_q <= ST_UNWARN;
          end
        end
        ST_UNWARN: begin
          // wait for the mirrored rising edge before primary activity resumes
          if (ackN) begin
            state_q <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (pgS && active_well_power_good && holdN) begin
            state_q <= ST_S0;
          end
        end
        default: begin
          state_q <= ST_S0;
        end
      endcase
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      suspend_warn_n <= RST_WARN_N;
    end else if (deepSleepSupported) begin
      suspend_warn_n <= ~warnLevel;
    end else begin
      // shared pin carries the power-down acknowledge, active high
      suspend_warn_n <= engineIdle && (state_q != ST_S0);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deep_sleep_state_n <= RST_DEEP_N;
    end else begin
      deep_sleep_state_n <= (state_q != ST_DEEP);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_off_sleep_n <= RST_SOFT_OFF_N;
    end else if (state_q == ST_S0) begin
      soft_off_sleep_n <= 1'b1;
    end else if (state_q == ST_SX && s5Req) begin
      soft_off_sleep_n <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      activeSleepCtl_n <= RST_ACTIVE_N;
    end else begin
      activeSleepCtl_n <= (state_q == ST_S0) || (state_q == ST_SX) || (state_q == ST_EXIT);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      suspend_clock_out <= 1'b0;
    end else begin
      suspend_clock_out <= rtcS;
    end
  end

  // ****************************************
  // internal active-well power good
  // ****************************************
  logic [PG_CNT_W-1:0] pgCnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pgCnt_q                <= '0;
      active_well_power_good <= 1'b0;
    end else if (!activeSleepCtl_n) begin
      pgCnt_q                <= '0;
      active_well_power_good <= 1'b0;
    end else if (pgCnt_q == PG_CNT_W'(ACTIVE_PG_CYCLES - 1)) begin
      active_well_power_good <= 1'b1;
    end else begin
      pgCnt_q <= pgCnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resetExit <= 1'b0;
      wakeTaken <= 1'b0;
    end else begin
      resetExit <= pgS && (state_q == ST_S0);
      wakeTaken <= wakeReq && ((state_q == ST_SX) || (state_q == ST_DEEP));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_deep_after_ack: assert property (@(posedge mclk) disable iff (rst)
    $fell(deep_sleep_state_n) |-> !ackN)
    else $error("deep sleep entered without acknowledge");
  chk_warn_before_deep: assert property (@(posedge mclk) disable iff (rst)
    !deep_sleep_state_n |-> !suspend_warn_n)
    else $error("deep sleep without warning");
  chk_deep_release: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_UNWARN) |=> deep_sleep_state_n)
    else $error("deep indication not released");
  chk_exit_holdoff: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_EXIT && !holdN) |=> state_q == ST_EXIT)
    else $error("exit despite holdoff");
  chk_exit_pgood: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_EXIT && !pgS) |=> state_q != ST_S0)
    else $error("exit without power good");
  chk_suspend_clock_out_copy: assert property (@(posedge mclk) disable iff (rst)
    suspend_clock_out == $past(rtcS))
    else $error("suspend clock not buffered");
  chk_apg_timing: assert property (@(posedge mclk) disable iff (rst)
    $rose(active_well_power_good) |-> $past(activeSleepCtl_n, 2) && activeSleepCtl_n)
    else $error("active power good early");
  chk_no_wake_warn: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_WARN) |=> !wakeTaken)
    else $error("wake during unacknowledged warning");
  chk_softoff_s5: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_SX && s5Req) |=> !soft_off_sleep_n)
    else $error("soft-off not asserted");
endmodule

// >>> tb/dsph_ctl_model.sv
// model of the power-sequencing controller on the suspend handshake
module dsph_ctl_model (
  input  wire logic       mclk,
  input  wire logic       deepSleepSupported,
  input  wire logic       suspend_warn_n,
  input  wire logic [7:0] ackLat,
  output logic            suspend_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] waitCnt;
  // pulled up, so an idle line reads deasserted
  initial suspend_ack_n = 1'b1;
  initial waitCnt = 8'h00;
  // preparing takes ackLat cycles; only deep-sleep platforms must follow
  always @(posedge mclk) begin
    if (suspend_warn_n === suspend_ack_n) waitCnt <= 8'h00;
    else if (deepSleepSupported && waitCnt >= ackLat) suspend_ack_n <= suspend_warn_n;
    else waitCnt <= waitCnt + 8'h01;
  end
endmodule

// >>> tb/dsph_top_test.sv
// self-checking bench for the deep-sleep power handshake sequencer
module dsph_top_test;
  import dsph_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, rtcClk = 1'b0, system_power_good = 1'b0;
  logic suspend_ack_n, sleep_exit_holdoff_n = 1'b1, deepSleepSupported = 1'b0;
  logic sleepReq = 1'b0, s5Req = 1'b0, deepReq = 1'b0, wakeReq = 1'b0, engineIdle = 1'b0;
  logic soft_off_sleep_n, deep_sleep_state_n, suspend_warn_n, suspend_clock_out;
  logic activeSleepCtl_n, active_well_power_good, resetExit, wakeTaken;
  logic sawWake = 1'b0;
  logic [3:0] rtcHist = 4'h0;
  logic [7:0] ackLat = 8'h14;
  // bits: strap, engine idle, expected shared pin
  logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b101, 3'b111};
  int n_mismatch = 0, cmp_count = 0, cyc = 0, k;

  dsph_top dut_u (.mclk(mclk), .rst(rst), .rtcClk(rtcClk),
    .system_power_good(system_power_good), .suspend_ack_n(suspend_ack_n),
    .sleep_exit_holdoff_n(sleep_exit_holdoff_n), .deepSleepSupported(deepSleepSupported),
    .sleepReq(sleepReq), .s5Req(s5Req), .deepReq(deepReq), .wakeReq(wakeReq),
    .engineIdle(engineIdle), .soft_off_sleep_n(soft_off_sleep_n),
    .deep_sleep_state_n(deep_sleep_state_n), .suspend_warn_n(suspend_warn_n),
    .suspend_clock_out(suspend_clock_out), .activeSleepCtl_n(activeSleepCtl_n),
    .active_well_power_good(active_well_power_good), .resetExit(resetExit),
    .wakeTaken(wakeTaken));
  dsph_ctl_model ctl_u (.mclk(mclk), .deepSleepSupported(deepSleepSupported),
    .suspend_warn_n(suspend_warn_n), .ackLat(ackLat), .suspend_ack_n(suspend_ack_n));

  always #2.5 mclk = ~mclk;

  task chk(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk) if (wakeTaken === 1'b1) sawWake <= 1'b1;

  // slow rtc stand-in; the output must lag it by three cycles
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 0) rtcClk <= ~rtcClk;
    rtcHist <= {rtcHist[2:0], rtcClk};
    if (!rst && cyc > 20 && cyc < 120) chk(suspend_clock_out, rtcHist[1], "suspend_clock_out");
    if (cyc == 5000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict;
    end
  end

  initial begin
    repeat (12) @(negedge mclk);
    chk(soft_off_sleep_n, RST_SOFT_OFF_N, "rst soft-off");
    chk(deep_sleep_state_n, RST_DEEP_N, "rst deep");
    chk(suspend_warn_n, RST_WARN_N, "rst warn");
    chk(activeSleepCtl_n, RST_ACTIVE_N, "rst active ctl");
    rst = 1'b0;
    engineIdle = 1'b1;
    repeat (3) @(negedge mclk);
    chk(soft_off_sleep_n, 1'b1, "soft-off in S0");
    chk(suspend_warn_n, 1'b0, "powerdown ack in S0");
    chk(resetExit, 1'b0, "exit without pg");
    repeat (ACTIVE_PG_CYCLES + 5) @(negedge mclk);
    chk(active_well_power_good, 1'b1, "active pg");
    system_power_good = 1'b1;
    repeat (5) @(negedge mclk);
    chk(resetExit, 1'b1, "exit with pg");
    sleepReq = 1'b1;
    @(negedge mclk);
    sleepReq = 1'b0;
    foreach (rows[i]) begin
      deepSleepSupported = rows[i][2];
      engineIdle = rows[i][1];
      repeat (4) @(negedge mclk);
      chk(suspend_warn_n, rows[i][0], "shared pin");
    end
    s5Req = 1'b1;
    @(negedge mclk);
    s5Req = 1'b0;
    @(negedge mclk);
    chk(soft_off_sleep_n, 1'b0, "soft-off in S5");
    engineIdle = 1'b0;
    deepReq = 1'b1;
    @(negedge mclk);
    deepReq = 1'b0;
    sawWake = 1'b0;
    wakeReq = 1'b1;
    repeat (3) @(negedge mclk);
    wakeReq = 1'b0;
    chk(suspend_warn_n, 1'b0, "warn on entry");
    chk(sawWake, 1'b0, "wake before ack");
    chk(deep_sleep_state_n, 1'b1, "deep before ack");
    for (k = 0; k < 80 && deep_sleep_state_n !== 1'b0; k++) @(negedge mclk);
    chk(deep_sleep_state_n, 1'b0, "deep entered");
    sleep_exit_holdoff_n = 1'b0;
    wakeReq = 1'b1;
    @(negedge mclk);
    wakeReq = 1'b0;
    for (k = 0; k < 80 && deep_sleep_state_n !== 1'b1; k++) @(negedge mclk);
    chk(deep_sleep_state_n, 1'b1, "deep left");
    repeat (300) @(negedge mclk);
    chk(resetExit, 1'b0, "held off");
    sleep_exit_holdoff_n = 1'b1;
    for (k = 0; k < 300 && resetExit !== 1'b1; k++) @(negedge mclk);
    chk(resetExit, 1'b1, "exit after holdoff");
    chk(soft_off_sleep_n, 1'b1, "soft-off released in S0");
    print_verdict;
  end
endmodule
